//--- rtl/adsbrs_encoder.sv
// top of the reed solomon parity encoder: fifo, parity register, output stage
// assumes the payload source sends exactly one message worth of bytes after start
`timescale 1ns/1ps
module adsbrs_encoder
	import adsbrs_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// message control
	input wire logic start_in,
	input wire logic long_sel_in,
	output logic busy_out,
	// payload in
	input wire logic in_valid_in,
	input wire logic [7:0] in_data_in,
	output logic in_ready_out,
	// codeword out
	output logic out_valid_out,
	output logic [7:0] out_data_out,
	output logic out_parity_out,
	output logic out_last_out,
	input wire logic out_ready_in
);
	adsbrs_stream_if #(.W(SYM_W)) st ();

	adsbrs_state_t state_r;
	adsbrs_state_t state_nxt;
	logic long_r;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [7:0] par_r [0:NMAX-1];
	logic [7:0] par_nxt [0:NMAX-1];
	logic [7:0] prod [0:NMAX-1];
	logic busy_r;
	logic out_valid_r;
	logic [7:0] out_data_r;
	logic out_parity_r;
	logic out_last_r;

	adsbrs_fifo #(
		.W(SYM_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.wr_valid_in(in_valid_in),
		.wr_data_in(in_data_in),
		.wr_ready_out(in_ready_out),
		.rd(st)
	);

	// handshake and sequencing terms
	wire out_free = !out_valid_r || out_ready_in;
	// a new start waits for the previous codeword to drain
	wire start_take = (state_r == ST_IDLE) && start_in && !out_valid_r;
	wire data_take = (state_r == ST_DATA) && st.valid && out_free;
	wire par_emit = (state_r == ST_PARITY) && out_free;
	wire [5:0] k_len = long_r ? K_LONG : K_SHORT;
	wire [5:0] n_len = long_r ? N_LONG : N_SHORT;
	wire last_data = data_take && (cnt_r == 6'(k_len - 6'h01));
	wire last_par = par_emit && (cnt_r == 6'(n_len - 6'h01));
	// feedback: incoming byte plus the most significant parity stage
	wire [7:0] fb = st.data ^ par_r[0];

	assign st.ready = (state_r == ST_DATA) && out_free;

	// parity register: stage 0 is the most significant and leaves first
	for (genvar gk = 0; gk < NMAX; gk++) begin : g_stage
		localparam logic [7:0] COEF_L = gf_alpha_pow(GEN_EXP_L[gk]);
		localparam logic [7:0] COEF_S = (gk < N_SHORT_INT) ?
			gf_alpha_pow(GEN_EXP_S[gk % N_SHORT_INT]) : ZERO_BYTE;
		wire [7:0] coef = long_r ? COEF_L : COEF_S;
		// short mode leaves the two low stages at zero, so stage 11 sees zero above
		wire [7:0] upper = (gk == NMAX-1) ? ZERO_BYTE : par_r[(gk+1) % NMAX];

		adsbrs_gf_mul u_mul (
			.a_in(fb),
			.b_in(coef),
			.p_out(prod[gk])
		);

		assign par_nxt[gk] = start_take ? ZERO_BYTE :
			data_take ? (upper ^ prod[gk]) :
			par_emit ? upper : par_r[gk];

		always_ff @(posedge clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				par_r[gk] <= ZERO_BYTE;
			end else begin
				par_r[gk] <= par_nxt[gk];
			end
		end
	end

	// sequence: idle, data, parity
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_take) begin
					state_nxt = ST_DATA;
				end
			end
			ST_DATA: begin
				if (last_data) begin
					state_nxt = ST_PARITY;
				end
			end
			ST_PARITY: begin
				if (last_par) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// byte counter within the current phase
	assign cnt_nxt = (start_take || last_data || last_par) ? 6'h00 :
		(data_take || par_emit) ? 6'(cnt_r + 6'h01) : cnt_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
			long_r <= 1'b0;
			cnt_r <= 6'h00;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			long_r <= start_take ? long_sel_in : long_r;
			cnt_r <= cnt_nxt;
			busy_r <= (state_nxt != ST_IDLE);
		end
	end

	// output stage: data passes unaltered, then parity msb stage first
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_valid_r <= 1'b0;
			out_data_r <= ZERO_BYTE;
			out_parity_r <= 1'b0;
			out_last_r <= 1'b0;
		end else if (data_take) begin
			out_valid_r <= 1'b1;
			out_data_r <= st.data;
			out_parity_r <= 1'b0;
			out_last_r <= 1'b0;
		end else if (par_emit) begin
			out_valid_r <= 1'b1;
			out_data_r <= par_r[0];
			out_parity_r <= 1'b1;
			out_last_r <= last_par;
		end else if (out_ready_in) begin
			out_valid_r <= 1'b0;
			out_last_r <= 1'b0;
		end
	end

	assign busy_out = busy_r;
	assign out_valid_out = out_valid_r;
	assign out_data_out = out_data_r;
	assign out_parity_out = out_parity_r;
	assign out_last_out = out_last_r;

	// checking helpers: position of each accepted byte inside the codeword
	wire out_hs = out_valid_r && out_ready_in;
	logic [5:0] out_idx_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_idx_r <= 6'h00;
		end else if (out_hs) begin
			out_idx_r <= out_last_r ? 6'h00 : 6'(out_idx_r + 6'h01);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_last_data;
		data_take && (cnt_r == 6'(k_len - 6'h01));
	endsequence

	sequence s_final_par;
		par_emit && (cnt_r == 6'(n_len - 6'h01));
	endsequence

	property p_data_pass;
		data_take |=> out_valid_out && !out_parity_out && (out_data_out == $past(st.data));
	endproperty
	a_data_pass: assert property (p_data_pass) else $error("data byte altered");

	property p_par_after;
		s_last_data |=> (state_r == ST_PARITY) && !st.ready ##1 (state_r == ST_PARITY);
	endproperty
	a_par_after: assert property (p_par_after) else $error("parity not after data");

	property p_par_first;
		par_emit |=> out_parity_out && (out_data_out == $past(par_r[0]));
	endproperty
	a_par_first: assert property (p_par_first) else $error("parity order wrong");

	property p_start_clear;
		start_take |=> (par_r[0] == ZERO_BYTE) && (par_r[NMAX-1] == ZERO_BYTE) && (cnt_r == 6'h00);
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("parity not cleared");

	property p_mode_hold;
		(state_r != ST_IDLE) |=> $stable(long_r);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("code changed mid message");

	property p_zero_fb;
		data_take && (fb == ZERO_BYTE) |=> (par_r[0] == $past(par_r[1]));
	endproperty
	a_zero_fb: assert property (p_zero_fb) else $error("zero feedback disturbed");

	property p_length;
		out_hs && out_last_r |-> (out_idx_r == 6'((long_r ? CW_LONG : CW_SHORT) - 6'h01));
	endproperty
	a_length: assert property (p_length) else $error("codeword length wrong");

	property p_final;
		s_final_par |=> (state_r == ST_IDLE) && out_last_out && out_parity_out;
	endproperty
	a_final: assert property (p_final) else $error("codeword end wrong");

	property p_hold;
		out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output dropped under stall");

	// extra guards: steps of the idle, data, parity walk, plus the output flag and fifo byte holds under stall
	property p_busy_state;
		busy_out == (state_r != ST_IDLE);
	endproperty
	a_busy_state: assert property (p_busy_state) else $error("busy out of step");

	property p_start_latch;
		start_take |=> (long_r == $past(long_sel_in)) && (state_r == ST_DATA) && busy_out;
	endproperty
	a_start_latch: assert property (p_start_latch) else $error("start not taken");

	// a start seen in mid-message must not restart the byte count
	property p_refuse_start;
		start_in && (state_r == ST_DATA) && !data_take |=> (cnt_r == $past(cnt_r));
	endproperty
	a_refuse_start: assert property (p_refuse_start) else $error("start not refused");

	property p_cnt_step;
		data_take && !last_data |=> (cnt_r == 6'($past(cnt_r) + 6'h01));
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("data count skipped");

	property p_par_hold;
		(state_r == ST_DATA) && !data_take |=> (par_r[0] == $past(par_r[0]));
	endproperty
	a_par_hold: assert property (p_par_hold) else $error("parity moved without data");

	property p_par_shift;
		par_emit |=> (par_r[0] == $past(par_r[1]));
	endproperty
	a_par_shift: assert property (p_par_shift) else $error("parity shift wrong");

	property p_par_drain;
		par_emit |=> (par_r[NMAX-1] == ZERO_BYTE);
	endproperty
	a_par_drain: assert property (p_par_drain) else $error("parity tail not emptied");

	// an off-by-one in the parity count leaves a nonzero stage behind
	property p_par_spent;
		s_final_par |=> (par_r[0] == ZERO_BYTE) && !busy_out;
	endproperty
	a_par_spent: assert property (p_par_spent) else $error("parity count wrong");

	property p_no_take;
		(state_r != ST_DATA) |-> !st.ready;
	endproperty
	a_no_take: assert property (p_no_take) else $error("byte taken outside data");

	// short code uses twelve stages; the two spare ones must stay empty
	property p_short_high;
		!long_r && (state_r != ST_IDLE) |->
			(par_r[N_SHORT_INT] == ZERO_BYTE) && (par_r[NMAX-1] == ZERO_BYTE);
	endproperty
	a_short_high: assert property (p_short_high) else $error("spare stage used");

	property p_cnt_data_bound;
		(state_r == ST_DATA) |-> (cnt_r < k_len);
	endproperty
	a_cnt_data_bound: assert property (p_cnt_data_bound) else $error("too many data");

	property p_cnt_par_bound;
		(state_r == ST_PARITY) |-> (cnt_r < n_len);
	endproperty
	a_cnt_par_bound: assert property (p_cnt_par_bound) else $error("too many parity");

	property p_data_zone;
		out_valid_out && !out_parity_out |-> (out_idx_r < k_len);
	endproperty
	a_data_zone: assert property (p_data_zone) else $error("data byte too late");

	property p_par_zone;
		out_valid_out && out_parity_out |-> (out_idx_r >= k_len);
	endproperty
	a_par_zone: assert property (p_par_zone) else $error("parity byte too early");

	property p_flag_hold;
		out_valid_out && !out_ready_in |=> $stable(out_parity_out) && $stable(out_last_out);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flags moved under stall");

	property p_last_is_par;
		out_last_out |-> out_valid_out && out_parity_out;
	endproperty
	a_last_is_par: assert property (p_last_is_par) else $error("last flag stray");

	property p_close;
		out_hs && (state_r == ST_IDLE) |=> !out_valid_out;
	endproperty
	a_close: assert property (p_close) else $error("byte after codeword end");

	// fifo must keep an offered byte steady until the core takes it
	property p_st_hold;
		st.valid && !st.ready |=> st.valid && $stable(st.data);
	endproperty
	a_st_hold: assert property (p_st_hold) else $error("payload byte slipped");
endmodule

//--- rtl/adsbrs_pkg.sv
// constants, field helpers and state type for the reed solomon parity encoder
// assumes one clock domain and a payload source that obeys valid/ready
package adsbrs_pkg;
	localparam int SYM_W = 8;
	localparam int CNT_W = 6;
	localparam int NMAX = 14;
	localparam int N_SHORT_INT = 12;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] FIELD_POLY = 8'h87;
	localparam logic [7:0] ALPHA_ONE = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [5:0] K_SHORT = 6'h12;
	localparam logic [5:0] N_SHORT = 6'h0C;
	localparam logic [5:0] CW_SHORT = 6'h1E;
	localparam logic [5:0] K_LONG = 6'h22;
	localparam logic [5:0] N_LONG = 6'h0E;
	localparam logic [5:0] CW_LONG = 6'h30;
	localparam int ROOT_FIRST = 120;
	localparam int ROOT_LAST_SHORT = 131;
	localparam int ROOT_LAST_LONG = 133;
	// generator exponents, x^(n-1) coefficient first
	localparam int GEN_EXP_S [12] = '{76, 66, 157, 28, 92, 220, 88, 20, 145, 50, 56, 231};
	localparam int GEN_EXP_L [14] = '{82, 49, 21, 70, 26, 140, 135, 138, 22, 64, 13, 39, 70,
		241};

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01,
		ST_PARITY = 2'b11
	} adsbrs_state_t;

	function automatic logic [7:0] gf_times_alpha(input logic [7:0] a);
		return a[7] ? ({a[6:0], 1'b0} ^ FIELD_POLY) : {a[6:0], 1'b0};
	endfunction

	// elaboration only: turns a printed exponent into its byte
	function automatic logic [7:0] gf_alpha_pow(input int e);
		logic [7:0] v;
		v = ALPHA_ONE;
		for (int i = 0; i < e; i++) begin
			v = gf_times_alpha(v);
		end
		return v;
	endfunction
endpackage

//--- rtl/adsbrs_stream_if.sv
// byte stream with valid/ready between the input fifo and the encoder core
// assumes both ends share one clock
`timescale 1ns/1ps
interface adsbrs_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- rtl/adsbrs_gf_mul.sv
// combinational multiplier over the 256-element field
// assumes operands in polynomial basis, msb the highest alpha power
`timescale 1ns/1ps
module adsbrs_gf_mul
	import adsbrs_pkg::*;
(
	// operands
	input wire logic [7:0] a_in,
	input wire logic [7:0] b_in,
	// product
	output logic [7:0] p_out
);
	logic [7:0] shifted [0:8];
	logic [7:0] acc [0:8];

	assign shifted[0] = a_in;
	assign acc[0] = ZERO_BYTE;
	// shift-and-add, reduced each step so no wide product exists
	for (genvar gi = 0; gi < SYM_W; gi++) begin : g_bit
		assign shifted[gi+1] = gf_times_alpha(shifted[gi]);
		assign acc[gi+1] = acc[gi] ^ (b_in[gi] ? shifted[gi] : ZERO_BYTE);
	end
	assign p_out = acc[8];
endmodule

//--- rtl/adsbrs_fifo.sv
// small synchronous fifo for payload bytes
// assumes one clock; ready on the fill side is registered
`timescale 1ns/1ps
module adsbrs_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// fill side
	input wire logic wr_valid_in,
	input wire logic [W-1:0] wr_data_in,
	output logic wr_ready_out,
	// drain side
	adsbrs_stream_if.src rd
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic ready_r;
	wire push = wr_valid_in && ready_r;
	wire pop = rd.valid && rd.ready;

	assign rd.valid = (count_r != '0);
	assign rd.data = mem[rp_r];
	assign wr_ready_out = ready_r;
	assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wp_r] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp_r <= '0;
			rp_r <= '0;
			count_r <= '0;
			ready_r <= 1'b0;
		end else begin
			wp_r <= push ? AW'(wp_r + 1'b1) : wp_r;
			rp_r <= pop ? AW'(rp_r + 1'b1) : rp_r;
			count_r <= count_nxt;
			// back-pressure: ready drops on the same edge that fills the last slot
			ready_r <= (count_nxt < (AW+1)'(D));
		end
	end
endmodule

//--- bench/adsbrs_src_model.sv
// payload source model: queues message bytes and offers them on valid/ready
// assumes the encoder samples valid and data on the rising clock edge
`timescale 1ns/1ps
module adsbrs_src_model (
	// clock
	input wire logic clk_in,
	// pacing: one idle cycle after each taken byte
	input wire logic slow_in,
	// payload
	output logic in_valid_out,
	output logic [7:0] in_data_out,
	input wire logic in_ready_in
);
	logic [7:0] q[$];
	logic took_r;

	initial begin
		in_valid_out = 1'b0;
		in_data_out = 8'hA5;
		took_r = 1'b0;
	end

	// leftmost message byte is queued first, its first bit on bit 7
	task automatic load(input logic [7:0] b);
		q.push_back(b);
	endtask

	always @(posedge clk_in) begin
		took_r <= in_valid_out && in_ready_in;
	end

	// a byte stands until taken; an idle bus toggles so stale data never looks valid
	always @(negedge clk_in) begin
		if (took_r) begin
			void'(q.pop_front());
		end
		if (q.size() > 0 && !(took_r && slow_in)) begin
			in_valid_out <= 1'b1;
			in_data_out <= q[0];
		end else begin
			in_valid_out <= 1'b0;
			in_data_out <= ~in_data_out;
		end
	end
endmodule

//--- bench/adsbrs_encoder_tb_top.sv
// self-checking bench for the reed solomon parity encoder
// assumes the source model feeds payload and the sink here paces the output
`timescale 1ns/1ps
module adsbrs_encoder_tb_top;
	import adsbrs_pkg::*;
	localparam int REF_EXP [12] = '{60, 145, 41, 128, 120, 183, 138, 76, 220, 90, 175, 71};
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic start_in = 1'b0;
	logic long_sel_in = 1'b0;
	logic slow = 1'b0;
	logic out_ready_in = 1'b0;
	logic busy_out, in_valid_in, in_ready_out, out_valid_out, out_parity_out, out_last_out;
	logic [7:0] in_data_in, out_data_out;
	logic [7:0] got_par[$];
	int bad_count = 0;
	int check_count = 0;
	int last_cyc;

	always #12.5 clk_in = ~clk_in;

	adsbrs_encoder i_adsbrs_encoder (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.start_in(start_in), .long_sel_in(long_sel_in), .busy_out(busy_out),
		.in_valid_in(in_valid_in), .in_data_in(in_data_in), .in_ready_out(in_ready_out),
		.out_valid_out(out_valid_out), .out_data_out(out_data_out),
		.out_parity_out(out_parity_out), .out_last_out(out_last_out),
		.out_ready_in(out_ready_in));

	adsbrs_src_model i_adsbrs_src_model (.clk_in(clk_in), .slow_in(slow),
		.in_valid_out(in_valid_in), .in_data_out(in_data_in), .in_ready_in(in_ready_out));

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, seen, want);
		end
	endtask

	// bitwise product, reduced on every shift
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			p = p[7] ? ({p[6:0], 1'b0} ^ 8'h87) : {p[6:0], 1'b0};
			if (b[i]) p = p ^ a;
		end
		return p;
	endfunction

	function automatic logic [7:0] apow(input int e);
		logic [7:0] v;
		v = 8'h01;
		for (int i = 0; i < e; i++) v = gmul(v, 8'h02);
		return v;
	endfunction

	// one message: expected codeword from a software parity register, then start and drain
	task automatic run_msg(input logic [271:0] v, input bit lng, input int stall, input bit fill);
		int k;
		int n;
		int got;
		int cyc;
		logic [7:0] d;
		logic [7:0] fb;
		logic [7:0] g;
		logic [7:0] par[14];
		logic [7:0] exp_q[$];
		k = lng ? 34 : 18;
		n = lng ? 14 : 12;
		par = '{default: 8'h00};
		got = 0;
		for (int i = 0; i < k; i++) begin
			d = v[8 * (k - 1 - i) +: 8];
			i_adsbrs_src_model.load(d);
			exp_q.push_back(d);
			fb = d ^ par[0];
			for (int j = 0; j < n; j++) begin
				g = apow(lng ? GEN_EXP_L[j] : GEN_EXP_S[j]);
				par[j] = (j < n - 1 ? par[j + 1] : 8'h00) ^ gmul(fb, g);
			end
		end
		for (int j = 0; j < n; j++) exp_q.push_back(par[j]);
		if (fill) begin
			repeat (12) @(negedge clk_in);
			check({7'h00, in_ready_out}, 8'h00); // four bytes held, fifo refuses more
		end
		@(negedge clk_in);
		long_sel_in = lng;
		start_in = 1'b1;
		@(negedge clk_in);
		start_in = 1'b0;
		long_sel_in = ~lng;
		check({7'h00, busy_out}, 8'h01);
		got_par.delete();
		for (cyc = 0; cyc < 2000 && got < k + n; cyc++) begin
			out_ready_in = (cyc % stall) == 0;
			// a start in mid-message with the other code must be ignored
			start_in = (cyc == 4);
			if (out_valid_out && out_ready_in) begin
				check(out_data_out, exp_q[got]);
				check({7'h00, out_parity_out}, {7'h00, got >= k});
				check({7'h00, out_last_out}, {7'h00, got == k + n - 1});
				if (got >= k) got_par.push_back(out_data_out);
				got++;
			end
			@(negedge clk_in);
		end
		last_cyc = cyc;
		start_in = 1'b0;
		out_ready_in = 1'b0;
		check(8'(got), 8'(k + n));
		repeat (2) @(negedge clk_in);
		check({7'h00, busy_out}, 8'h00);
		check({7'h00, out_valid_out}, 8'h00);
	endtask

	task automatic t_short_ref();
		run_msg(272'(144'h00FAA123555555C000000354064432C02800), 1'b0, 1, 1'b0);
		for (int i = 0; i < 12; i++) begin
			check(got_par[i], apow(REF_EXP[i]));
		end
		// one byte per clock: start latency of two plus a few bubbles at most
		check({7'h00, last_cyc <= 36}, 8'h01);
		$display("short reference message done");
	endtask

	task automatic t_long_slow();
		slow = 1'b1;
		run_msg(272'h10FAA123555555C000000354064432C0280E1B4D090CFC0488740000000350000000,
			1'b1, 3, 1'b0);
		slow = 1'b0;
		$display("long message with slow source and stalled sink done");
	endtask

	// zero payload after a long message: parity must restart from zero
	task automatic t_fill_zero();
		run_msg(272'h0, 1'b0, 2, 1'b1);
		$display("prefilled zero message done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge clk_in);
		check({7'h00, in_ready_out}, 8'h00);
		rst_b_in = 1'b1;
		repeat (2) @(negedge clk_in);
		check({7'h00, in_ready_out}, 8'h01);
		t_short_ref();
		t_long_slow();
		t_fill_zero();
		close_out();
	end

	// three messages need a few hundred cycles; 80000 cycles means a hang
	initial begin
		#2000000;
		bad_count++;
		close_out();
	end
endmodule
